//--- core/ccw_map.svh
`ifndef CCW_MAP_SVH
`define CCW_MAP_SVH
// ------------------------------------------------------------
// Cache control word layout
// ------------------------------------------------------------
`define CCW_ON_BIT   31
`define CCW_SQ_BIT   29
`define CCW_KAP_BIT  28
`define CCW_HL_BIT   27
`define CCW_FL_BIT   24
`define CCW_POL_HI   9
`define CCW_POL_LO   8
`define CCW_SG_BIT   5
// Writable bits; all others read as zero
`define CCW_WMASK    32'hb900_0320
// Reset value of the whole word
`define CCW_RESET    32'h0000_0000
// ------------------------------------------------------------
// Sweep geometry
// ------------------------------------------------------------
`define CCW_SETS     128
`define CCW_WAYS     4
`endif

//--- core/ccw_pkg.sv
package ccw_pkg;
  // Region policy encodings
  typedef enum logic [1:0] {
    CCW_POL_WT   = 2'h0,
    CCW_POL_CB   = 2'h1,
    CCW_POL_CIP  = 2'h2,
    CCW_POL_CII  = 2'h3
  } ccw_pol_t;

  // Invalidate-all sequencer states
  typedef enum logic [1:0] {
    CCW_ST_IDLE  = 2'h1,
    CCW_ST_SWEEP = 2'h2
  } ccw_st_t;

  // Decoded control fields
  typedef struct packed {
    logic     cache_on;
    logic     store_queue_on;
    logic     keep_after_push;
    logic     half_lock;
    logic     flush_all_trigger;
    ccw_pol_t default_region_policy;
    logic     default_store_guard;
  } ccw_cfg_t;

  // Register write from one source
  typedef struct packed {
    logic        wr;
    logic [31:0] data;
  } ccw_wr_t;
endpackage

//--- core/ccw_victim_sel.sv
`timescale 1ns/100ps
`include "ccw_map.svh"
// ------------------------------------------------------------
// Allocation way picker
// ------------------------------------------------------------
module ccw_victim_sel
  import ccw_pkg::*;
(
  // Set state
  input  wire logic [3:0] way_valid,
  input  wire logic       half_lock,
  input  wire logic [1:0] rr,
  // Choice
  output logic      [1:0] way,
  output logic            use_rr
);
  // Lowest invalid way (of ways 2/3 only when locked), else counter choice
  always_comb begin
    use_rr = 1'b0;
    way    = 2'h0;
    if (half_lock) begin
      if (!way_valid[2]) begin
        way = 2'h2;
      end else if (!way_valid[3]) begin
        way = 2'h3;
      end else begin
        use_rr = 1'b1;
        way    = rr[1] ? 2'h3 : 2'h2;
      end
    end else begin
      if (!way_valid[0]) begin
        way = 2'h0;
      end else if (!way_valid[1]) begin
        way = 2'h1;
      end else if (!way_valid[2]) begin
        way = 2'h2;
      end else if (!way_valid[3]) begin
        way = 2'h3;
      end else begin
        use_rr = 1'b1;
        way    = rr;
      end
    end
  end
endmodule

//--- core/ccw_ctrl.sv
`timescale 1ns/100ps
`include "ccw_map.svh"
// Overview of operation
// - Reset clears control word, cache content kept
// - Core writes word; debug reads and writes
// - Bit 31 enables cache operation
// - Store queue off: writes go direct
// - Store queue on: imprecise writes queued
// - Inhibited precise writes never queued
// - Keep bit clear: push then invalidate
// - Keep bit set: push, line stays valid
// - Normal: lowest invalid way, else counter
// - Locked: ways 2/3 only, counter high bit
// - Locked ways still take write hits
// - Lock bit may change any time
// - Flush bit sweeps all sets clear
// - Flush bit clears itself when done
// - Accesses stall until sweep completes
// - Bits 9..8 give default region policy
// - Bit 5 blocks default-region writes
module ccw_ctrl
  import ccw_pkg::*;
#(
  parameter int NUM_SETS = `CCW_SETS,
  parameter int SET_W    = $clog2(`CCW_SETS)
) (
  // Clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  // Control-move write from the core
  input  wire ccw_wr_t          mv,
  // Debug access
  input  wire ccw_wr_t          dbg,
  input  wire logic             dbg_rd,
  output logic [31:0]           dbg_rdata,
  output logic                  dbg_rvalid,
  // Decoded fields
  output ccw_cfg_t              cfg,
  // Cache access gate
  input  wire logic             acc_req,
  output logic                  acc_stall,
  output logic                  acc_grant,
  // Write routing
  input  wire logic             wr_req,
  input  wire logic             wr_pol_ovr,
  input  wire ccw_pol_t         wr_pol,
  output logic                  wr_use_sq,
  output logic                  wr_blocked,
  // Line push
  input  wire logic             push_req,
  input  wire logic             push_line_mod,
  output logic                  push_wb,
  output logic                  push_inval,
  // Allocation
  input  wire logic             alloc_req,
  input  wire logic [3:0]       way_valid,
  output logic [1:0]            alloc_way,
  // Invalidate-all sweep
  output logic                  flush_clr,
  output logic [SET_W-1:0]      flush_set
);
  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  logic [31:0]      ctl_q, ctl_d;         // Control word
  ccw_st_t          st_q, st_d;           // Sweep state
  logic [SET_W-1:0] set_q, set_d;         // Sweep index
  logic [1:0]       rr_q, rr_d;           // Round-robin counter
  logic [31:0]      rdat_q, rdat_d;       // Debug read data
  logic             rv_q, rv_d;           // Debug read valid
  logic             sweep_last;           // Last set this cycle
  ccw_wr_t          wsel;                 // Chosen writer
  ccw_pol_t         eff_pol;              // Policy of this write
  logic             use_rr;               // Counter drove choice
  logic [1:0]       pick;                 // Picked way

  localparam logic [SET_W-1:0] LAST_SET = SET_W'(NUM_SETS - 1);

  // ----------------------------------------------------------
  // Control word
  // ----------------------------------------------------------
  // Debug write wins over a same-cycle core write
  always_comb begin
    wsel  = dbg.wr ? dbg : mv;
    ctl_d = ctl_q;
    if (wsel.wr) begin
      ctl_d = wsel.data & `CCW_WMASK;
      // Writing zero never aborts a pending or running sweep
      if (ctl_q[`CCW_FL_BIT]) begin
        ctl_d[`CCW_FL_BIT] = 1'b1;
      end
    end
    // Self clear at sweep end unless a new trigger lands
    if (sweep_last && !(wsel.wr && wsel.data[`CCW_FL_BIT])) begin
      ctl_d[`CCW_FL_BIT] = 1'b0;
    end
  end

  // Register the word
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctl_q <= `CCW_RESET;
    end else if (ce) begin
      ctl_q <= ctl_d;
    end
  end

  // Field view of the word
  assign cfg.cache_on              = ctl_q[`CCW_ON_BIT];
  assign cfg.store_queue_on        = ctl_q[`CCW_SQ_BIT];
  assign cfg.keep_after_push       = ctl_q[`CCW_KAP_BIT];
  assign cfg.half_lock             = ctl_q[`CCW_HL_BIT];
  assign cfg.flush_all_trigger     = ctl_q[`CCW_FL_BIT];
  assign cfg.default_region_policy = ccw_pol_t'(ctl_q[`CCW_POL_HI:`CCW_POL_LO]);
  assign cfg.default_store_guard   = ctl_q[`CCW_SG_BIT];

  // ----------------------------------------------------------
  // Debug read port
  // ----------------------------------------------------------
  // Capture word in the request cycle, answer one cycle later
  always_comb begin
    rv_d   = dbg_rd;
    rdat_d = dbg_rd ? ctl_q : rdat_q;
  end

  // Register read data
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rv_q   <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else if (ce) begin
      rv_q   <= rv_d;
      rdat_q <= rdat_d;
    end
  end

  assign dbg_rvalid = rv_q;
  assign dbg_rdata  = rdat_q;

  // ----------------------------------------------------------
  // Invalidate-all sweep
  // ----------------------------------------------------------
  assign sweep_last = (st_q == CCW_ST_SWEEP) && (set_q == LAST_SET);

  // Walk every set once, one per cycle
  always_comb begin
    st_d  = st_q;
    set_d = set_q;
    unique case (st_q)
      CCW_ST_IDLE: begin
        if (ctl_q[`CCW_FL_BIT]) begin
          st_d  = CCW_ST_SWEEP;
          set_d = '0;
        end
      end
      CCW_ST_SWEEP: begin
        if (sweep_last) begin
          st_d  = CCW_ST_IDLE;
          set_d = '0;
        end else begin
          set_d = set_q + SET_W'(1);
        end
      end
      default: begin
        st_d  = CCW_ST_IDLE;
        set_d = '0;
      end
    endcase
  end

  // Register sweep state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q  <= CCW_ST_IDLE;
      set_q <= '0;
    end else if (ce) begin
      st_q  <= st_d;
      set_q <= set_d;
    end
  end

  assign flush_clr = (st_q == CCW_ST_SWEEP);
  assign flush_set = set_q;

  // ----------------------------------------------------------
  // Access gate and write routing
  // ----------------------------------------------------------
  // Any access while the flush bit stands is held
  assign acc_stall = acc_req && ctl_q[`CCW_FL_BIT];
  // Grant covers write hits to any way, locked or not
  assign acc_grant = acc_req && !acc_stall && cfg.cache_on;

  assign eff_pol = wr_pol_ovr ? wr_pol : cfg.default_region_policy;

  // Queue only write-through and imprecise inhibited writes
  always_comb begin
    wr_use_sq = 1'b0;
    if (wr_req && cfg.store_queue_on) begin
      wr_use_sq = (eff_pol == CCW_POL_WT) || (eff_pol == CCW_POL_CII);
    end
  end

  // Default regions refuse writes when guarded
  assign wr_blocked = wr_req && !wr_pol_ovr && cfg.default_store_guard;

  // ----------------------------------------------------------
  // Line push
  // ----------------------------------------------------------
  assign push_wb    = push_req && push_line_mod;
  assign push_inval = push_req && !cfg.keep_after_push;

  // ----------------------------------------------------------
  // Allocation
  // ----------------------------------------------------------
  ccw_victim_sel u_sel (
    .way_valid (way_valid),
    .half_lock (cfg.half_lock),
    .rr        (rr_q),
    .way       (pick),
    .use_rr    (use_rr)
  );

  assign alloc_way = pick;

  // Lock bit is read live, so it may flip between allocations
  always_comb begin
    rr_d = rr_q;
    if (alloc_req && use_rr) begin
      if (cfg.half_lock) begin
        rr_d = {~rr_q[1], rr_q[0]};
      end else begin
        rr_d = rr_q + 2'h1;
      end
    end
  end

  // Register the counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rr_q <= 2'h0;
    end else if (ce) begin
      rr_q <= rr_d;
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  chk_reset_clear: assert property (@(posedge clk) !rst_b |=> ctl_q == 32'h0)
    else $error("control word not cleared by reset");

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || !ce);

  chk_core_write: assert property (
    (mv.wr && !dbg.wr && !cfg.flush_all_trigger) |=> ctl_q == ($past(mv.data) & `CCW_WMASK))
    else $error("core write not stored");
  chk_debug_read: assert property (dbg_rd |=> dbg_rvalid && dbg_rdata == $past(ctl_q))
    else $error("debug read wrong");
  chk_off_grant: assert property (!cfg.cache_on |-> !acc_grant)
    else $error("grant while cache off");
  chk_sq_route: assert property (
    wr_use_sq |-> cfg.store_queue_on && eff_pol != CCW_POL_CB)
    else $error("store queue used wrongly");
  chk_precise_byp: assert property (eff_pol == CCW_POL_CIP |-> !wr_use_sq)
    else $error("precise write queued");
  chk_push_inval: assert property (push_req |-> push_inval != cfg.keep_after_push)
    else $error("push invalidate wrong");
  chk_lock_ways: assert property (alloc_req && cfg.half_lock |-> alloc_way[1])
    else $error("locked way allocated");
  chk_rr_step: assert property (
    alloc_req && !cfg.half_lock && &way_valid |=> rr_q == $past(rr_q) + 2'h1)
    else $error("counter did not advance");
  chk_flush_done: assert property (
    sweep_last && !wsel.wr |=> !cfg.flush_all_trigger ##1 st_q == CCW_ST_IDLE)
    else $error("flush bit not self cleared");
  chk_flush_stall: assert property (flush_clr && acc_req |-> acc_stall && !acc_grant)
    else $error("access during sweep");
  chk_reserved_zero: assert property ((ctl_q & ~`CCW_WMASK) == 32'h0)
    else $error("reserved bit set");
  // Busy flag survives any write until the last set
  chk_flush_hold: assert property (
    cfg.flush_all_trigger && !sweep_last |=> cfg.flush_all_trigger)
    else $error("flush bit dropped early");
  // Locked counter flips its high bit only
  chk_rr_lock: assert property (
    alloc_req && cfg.half_lock && &way_valid[3:2]
    |=> rr_q[1] != $past(rr_q[1]) && rr_q[0] == $past(rr_q[0]))
    else $error("locked counter step wrong");
  // Counter idle without an allocation
  chk_rr_hold: assert property (!alloc_req |=> $stable(rr_q))
    else $error("counter moved without allocation");

  // Main scenarios
  cov_sweep_end: cover property (sweep_last ##1 !cfg.flush_all_trigger);
  cov_lock_way3: cover property (alloc_req && cfg.half_lock && alloc_way == 2'h3);
  cov_push_keep: cover property (push_req && push_line_mod && !push_inval);
  cov_sq_write: cover property (wr_use_sq && eff_pol == CCW_POL_CII);
  cov_flush_zero: cover property (cfg.flush_all_trigger && wsel.wr && !wsel.data[`CCW_FL_BIT]);
endmodule

//--- tb/ccw_core_mdl.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Core and debug side of the control word
// ------------------------------------------------------------
module ccw_core_mdl
  import ccw_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Requests toward the block
  output ccw_wr_t          mv,
  output ccw_wr_t          dbg,
  output logic             dbg_rd,
  // Read answer
  input  wire logic [31:0] dbg_rdata,
  input  wire logic        dbg_rvalid
);
  // Idle at time zero
  initial begin
    mv = '0;
    dbg = '0;
    dbg_rd = 1'b0;
  end

  // One-cycle word write from core or debug
  task automatic put(input logic use_dbg, input logic [31:0] d);
    @(negedge clk);
    if (use_dbg) begin
      dbg = '{1'b1, d};
    end else begin
      mv = '{1'b1, d};
    end
    @(negedge clk);
    mv = '{1'b0, ~d};
    dbg = '{1'b0, ~d};
  endtask

  // Debug read, answer one cycle later
  task automatic get(output logic [31:0] d, output logic v);
    @(negedge clk);
    dbg_rd = 1'b1;
    @(negedge clk);
    dbg_rd = 1'b0;
    d = dbg_rdata;
    v = dbg_rvalid;
  endtask
endmodule

//--- tb/ccw_ctrl_tb.sv
`timescale 1ns/100ps
module ccw_ctrl_tb
  import ccw_pkg::*;
;
  localparam int NS = 8;  // Short sweep
  // Stimulus and observed nets
  logic clk = 1'b0, rst_b = 1'b0, acc_req = 1'b0, wr_req = 1'b0, wr_pol_ovr = 1'b0;
  logic push_req = 1'b0, push_line_mod = 1'b0, alloc_req = 1'b0, ce = 1'b1;
  logic [3:0] way_valid = 4'h0;
  ccw_pol_t wr_pol = CCW_POL_WT;
  ccw_wr_t mv, dbg;
  logic dbg_rd, dbg_rvalid, acc_stall, acc_grant, wr_use_sq, wr_blocked;
  logic push_wb, push_inval, flush_clr, v;
  logic [31:0] dbg_rdata, d;
  logic [1:0] alloc_way;
  logic [2:0] flush_set;
  ccw_cfg_t cfg;
  int bad_count = 0, samples_checked = 0;

  always #20 clk = ~clk;

  ccw_ctrl #(.NUM_SETS(NS), .SET_W(3)) dut_u (.clk(clk), .rst_b(rst_b), .ce(ce),
    .mv(mv), .dbg(dbg), .dbg_rd(dbg_rd), .dbg_rdata(dbg_rdata), .dbg_rvalid(dbg_rvalid),
    .cfg(cfg), .acc_req(acc_req), .acc_stall(acc_stall), .acc_grant(acc_grant),
    .wr_req(wr_req), .wr_pol_ovr(wr_pol_ovr), .wr_pol(wr_pol), .wr_use_sq(wr_use_sq),
    .wr_blocked(wr_blocked), .push_req(push_req), .push_line_mod(push_line_mod),
    .push_wb(push_wb), .push_inval(push_inval), .alloc_req(alloc_req),
    .way_valid(way_valid), .alloc_way(alloc_way), .flush_clr(flush_clr),
    .flush_set(flush_set));
  ccw_core_mdl mdl_u (.clk(clk), .mv(mv), .dbg(dbg), .dbg_rd(dbg_rd),
    .dbg_rdata(dbg_rdata), .dbg_rvalid(dbg_rvalid));

  // ------------------------------------------------------------
  // Compare and verdict
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Word layout, masking, both writers
  task automatic t_regs();
    mdl_u.get(d, v);
    chk("rvalid", 1, v);
    chk("reset word", 0, d);
    mdl_u.put(0, 32'hfeff_ffff);
    chk("cache_on", 1, cfg.cache_on);
    mdl_u.get(d, v);
    chk("masked word", 32'hb800_0320, d);
    mdl_u.put(1, 32'h4000_0120);
    mdl_u.get(d, v);
    chk("debug word", 32'h0000_0120, d);
    chk("cache_off", 0, cfg.cache_on);
    // Enable low: the write must not land
    ce = 1'b0;
    mdl_u.put(0, 32'h8000_0000);
    chk("frozen word", 0, cfg.cache_on);
    ce = 1'b1;
  endtask

  // Store queue use for every policy, and write guard
  task automatic t_route();
    wr_req = 1'b1;
    for (int i = 0; i < 8; i++) begin
      mdl_u.put(0, 32'h8000_0000 | ((i & 1) << 29) | ((i >> 1) << 8));
      chk("use_sq", (i & 1) && (i >> 1 == 0 || i >> 1 == 3), wr_use_sq);
    end
    wr_pol_ovr = 1'b1;
    wr_pol = CCW_POL_CIP;
    #1 chk("precise sq", 0, wr_use_sq);
    mdl_u.put(0, 32'h0000_0020);
    chk("guard ovr", 0, wr_blocked);
    wr_pol_ovr = 1'b0;
    #1 chk("guard", 1, wr_blocked);
    wr_req = 1'b0;
  endtask

  // Line push with and without keep
  task automatic t_push();
    push_req = 1'b1;
    push_line_mod = 1'b1;
    for (int k = 0; k < 2; k++) begin
      mdl_u.put(0, k << 28);
      chk("push_wb", 1, push_wb);
      chk("push_inval", !k, push_inval);
    end
    push_line_mod = 1'b0;
    #1 chk("push clean", 0, push_wb);
    push_req = 1'b0;
  endtask

  // Allocation, lock set part way through
  task automatic t_alloc();
    logic [3:0] vv [11] = '{4'h6, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h3, 4'h7, 4'hf, 4'hf, 4'hf};
    logic [1:0] ew [11] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2};
    acc_req = 1'b1;
    mdl_u.put(0, 32'h8000_0000);
    for (int i = 0; i < 11; i++) begin
      // Strobe stays up between steps, drops only around the lock write
      if (i == 6) begin
        alloc_req = 1'b0;
        mdl_u.put(0, 32'h8800_0000);
      end
      way_valid = vv[i];
      alloc_req = 1'b1;
      #1 chk("alloc_way", ew[i], alloc_way);
      @(negedge clk);
    end
    alloc_req = 1'b0;
    chk("locked grant", 1, acc_grant);
  endtask

  // Whole-cache sweep, stall and self clear; nothing dirty beforehand
  task automatic t_flush();
    int n = 2;  // Sets 0 and 1 pass while the zero write goes in
    mdl_u.put(0, 32'h8100_0000);
    chk("stall", 1, acc_stall);
    chk("no grant", 0, acc_grant);
    mdl_u.put(1, 32'h8000_0000);
    chk("zero write", 1, cfg.flush_all_trigger);
    chk("stall kept", 1, acc_stall);
    for (int c = 0; c < 4 * NS; c++) begin
      @(negedge clk);
      if (flush_clr === 1'b1) begin
        chk("flush_set", n, flush_set);
        chk("stall on", 1, acc_stall);
        n++;
      end
    end
    chk("sets swept", NS, n);
    mdl_u.get(d, v);
    chk("self clear", 32'h8000_0000, d);
    chk("grant after", 1, acc_grant);
  endtask

  // Mid-run reset clears the word again
  task automatic t_rst();
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    mdl_u.get(d, v);
    chk("rvalid after reset", 1, v);
    chk("word after reset", 0, d);
    chk("grant after reset", 0, acc_grant);
  endtask

  // Hang guard
  initial begin
    #(40 * 2000);
    bad_count++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    t_regs();
    t_route();
    t_push();
    t_alloc();
    t_flush();
    t_rst();
    summarize();
  end
endmodule
